/* common/irq_gate_pkg.sv */
package irq_gate_pkg;
    localparam int REG_W = 16;
    localparam int ADDR_W = 4;
    // register word offsets (Avalon word addresses)
    localparam logic [3:0] OFS_PEND_LO = 4'h0;
    localparam logic [3:0] OFS_PEND_HI = 4'h1;
    localparam logic [3:0] OFS_EN_LO = 4'h2;
    localparam logic [3:0] OFS_EN_HI = 4'h3;
    localparam logic [3:0] OFS_TC_LO = 4'h4;
    localparam logic [3:0] OFS_TC_HI = 4'h5;
    localparam logic [3:0] OFS_CTRL = 4'h6;
    localparam logic [3:0] OFS_STATUS = 4'h7;
    // implemented bits: low registers bits 15..2, high registers 10..0
    localparam logic [15:0] LO_MASK = 16'hfffc;
    localparam logic [15:0] HI_MASK = 16'h07ff;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam int BIT_BUS_FAULT = 8;
    localparam int BIT_TRACE_LOG = 9;
    localparam int BIT_OS_EVENT = 10;
    localparam int CTRL_SOFT_RESET = 0;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } bus_state_t;
endpackage : irq_gate_pkg

/* src/irq_select.sv */
`timescale 1ns/1ps
// per-vector gating of one 16-bit register group
module irq_select #(
    parameter int W = 16
) (
    input wire logic [W-1:0] pending,
    input wire logic [W-1:0] enable,
    input wire logic [W-1:0] tc_enable,
    input wire logic [W-1:0] valid_mask,
    input wire logic rt_halted,
    output logic [W-1:0] request
);
    always_comb begin
        if (rt_halted) begin
            request = pending & enable & tc_enable & valid_mask; // R12 R20
        end else begin
            request = pending & enable & valid_mask; // R3 R11 R20
        end
    end
endmodule : irq_select

/* src/irq_gate.sv */
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
// Functional notes
// R1 - pending flag reads 1 while pending
// R2 - writing 1 clears flag, 0 no effect
// R3 - enable bit 1 enables that interrupt
// R4 - hardware reset clears both enable registers
// R5 - software reset keeps enable registers
// R6 - software programs enables before unmasking globally
// R7 - high enable bits 10,9,8 os/trace/fault
// R8 - high enable bits 7..0 are vectors 23..16
// R9 - low enable bit n is vector n
// R10 - reserved bits read zero, read-only
// R11 - debug enables only matter while halted
// R12 - halted: need debug and normal enable
// R13 - debug enable registers read and write
// R14 - software reset keeps debug enables
// R15 - hardware reset clears debug enables
// R16 - software programs debug enables before use
// R17 - incoming request sets pending flag
// R18 - acknowledge clears pending flag
// R19 - device reset clears all pending flags
// R20 - request only when pending and enabled
module irq_gate #(
    parameter int W = 16
) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [W-1:0] IRQ_IN_LO,
    input wire logic [W-1:0] IRQ_IN_HI,
    input wire logic [W-1:0] ACK_LO,
    input wire logic [W-1:0] ACK_HI,
    input wire logic RT_HALTED,
    output logic [W-1:0] IRQ_OUT_LO,
    output logic [W-1:0] IRQ_OUT_HI
);
    logic [W-1:0] pend_lo;
    logic [W-1:0] pend_hi;
    logic [W-1:0] en_lo;
    logic [W-1:0] en_hi;
    logic [W-1:0] tc_lo;
    logic [W-1:0] tc_hi;
    logic [W-1:0] req_lo;
    logic [W-1:0] req_hi;
    logic [W-1:0] wdata;
    logic [W-1:0] bmask;
    logic [W-1:0] next_rdata;
    logic wr_now;
    logic rd_now;
    logic soft_reset_seen;
    logic [W-1:0] clr_lo;
    logic [W-1:0] clr_hi;
    logic [W-1:0] next_pend_lo;
    logic [W-1:0] next_pend_hi;
    irq_gate_pkg::bus_state_t bus_state;

    // byte enables expanded to a 16-bit lane mask
    function automatic logic [15:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    // write-one-to-clear applied under lane mask
    function automatic logic [15:0] w1c_bits(input logic [15:0] d,
                                             input logic [15:0] m,
                                             input logic [15:0] v);
        w1c_bits = d & m & v;
    endfunction : w1c_bits

    assign wdata = AVS_WRITEDATA[15:0];
    assign bmask = lane_mask(AVS_BYTEENABLE);
    // every access takes one wait cycle, the answer comes in BUS_ACK
    assign wr_now = AVS_WRITE && (bus_state == irq_gate_pkg::BUS_ACK);
    assign rd_now = AVS_READ && (bus_state == irq_gate_pkg::BUS_ACK);

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            bus_state <= irq_gate_pkg::BUS_IDLE;
        end else begin
            case (bus_state)
                irq_gate_pkg::BUS_IDLE: begin
                    if (AVS_READ || AVS_WRITE) begin
                        bus_state <= irq_gate_pkg::BUS_ACK;
                    end
                end
                irq_gate_pkg::BUS_ACK: begin
                    bus_state <= irq_gate_pkg::BUS_IDLE;
                end
                default: begin
                    bus_state <= irq_gate_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            // low exactly during the acknowledge cycle
            AVS_WAITREQUEST <= !((bus_state == irq_gate_pkg::BUS_IDLE)
                                 && (AVS_READ || AVS_WRITE));
        end
    end

    // set wins over clear: a request arriving with a clear is kept
    always_comb begin
        clr_lo = ACK_LO; // R18
        clr_hi = ACK_HI; // R18
        if (wr_now && AVS_ADDRESS == irq_gate_pkg::OFS_PEND_LO) begin
            clr_lo = clr_lo | w1c_bits(wdata, bmask,
                                       irq_gate_pkg::LO_MASK); // R2
        end
        if (wr_now && AVS_ADDRESS == irq_gate_pkg::OFS_PEND_HI) begin
            clr_hi = clr_hi | w1c_bits(wdata, bmask,
                                       irq_gate_pkg::HI_MASK); // R2
        end
        next_pend_lo = ((pend_lo & ~clr_lo) | IRQ_IN_LO)
                       & irq_gate_pkg::LO_MASK; // R17
        next_pend_hi = ((pend_hi & ~clr_hi) | IRQ_IN_HI)
                       & irq_gate_pkg::HI_MASK; // R17
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            pend_lo <= irq_gate_pkg::ZERO16; // R19
            pend_hi <= irq_gate_pkg::ZERO16; // R19
        end else begin
            pend_lo <= next_pend_lo;
            pend_hi <= next_pend_hi;
        end
    end

    // enables: cleared by the hardware reset input or by writing zeros, not by the software reset strobe
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            en_lo <= irq_gate_pkg::ZERO16; // R4
            en_hi <= irq_gate_pkg::ZERO16; // R4
        end else begin
            if (wr_now && AVS_ADDRESS == irq_gate_pkg::OFS_EN_LO) begin
                en_lo <= ((en_lo & ~bmask) | (wdata & bmask))
                         & irq_gate_pkg::LO_MASK; // R9 R10
            end
            if (wr_now && AVS_ADDRESS == irq_gate_pkg::OFS_EN_HI) begin
                en_hi <= ((en_hi & ~bmask) | (wdata & bmask))
                         & irq_gate_pkg::HI_MASK; // R7 R8 R10
            end
        end
    end

    // time-critical (debug) enables
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            tc_lo <= irq_gate_pkg::ZERO16; // R15
            tc_hi <= irq_gate_pkg::ZERO16; // R15
        end else begin
            if (wr_now && AVS_ADDRESS == irq_gate_pkg::OFS_TC_LO) begin
                tc_lo <= ((tc_lo & ~bmask) | (wdata & bmask))
                         & irq_gate_pkg::LO_MASK; // R13
            end
            if (wr_now && AVS_ADDRESS == irq_gate_pkg::OFS_TC_HI) begin
                tc_hi <= ((tc_hi & ~bmask) | (wdata & bmask))
                         & irq_gate_pkg::HI_MASK; // R13
            end
        end
    end

    // software reset strobe: records the event only; enable and
    // debug enable registers are deliberately untouched by it
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            soft_reset_seen <= 1'b0;
        end else if (wr_now && AVS_ADDRESS == irq_gate_pkg::OFS_CTRL
                     && wdata[irq_gate_pkg::CTRL_SOFT_RESET]) begin
            soft_reset_seen <= 1'b1; // R5 R14
        end else if (wr_now && AVS_ADDRESS == irq_gate_pkg::OFS_STATUS) begin
            soft_reset_seen <= 1'b0;
        end
    end

    always_comb begin
        case (AVS_ADDRESS)
            irq_gate_pkg::OFS_PEND_LO: next_rdata = pend_lo; // R1
            irq_gate_pkg::OFS_PEND_HI: next_rdata = pend_hi; // R1
            irq_gate_pkg::OFS_EN_LO: next_rdata = en_lo; // R10
            irq_gate_pkg::OFS_EN_HI: next_rdata = en_hi; // R10
            irq_gate_pkg::OFS_TC_LO: next_rdata = tc_lo; // R13
            irq_gate_pkg::OFS_TC_HI: next_rdata = tc_hi; // R13
            irq_gate_pkg::OFS_STATUS: next_rdata = {14'h0000,
                                                   soft_reset_seen,
                                                   RT_HALTED};
            default: next_rdata = irq_gate_pkg::ZERO16;
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            AVS_READDATA <= irq_gate_pkg::UNMAPPED_READ;
        end else if ((bus_state == irq_gate_pkg::BUS_IDLE) && AVS_READ) begin
            AVS_READDATA <= {16'h0000, next_rdata};
        end
    end

    irq_select #(
        .W(W)
    ) u_sel_lo (
        .pending(pend_lo),
        .enable(en_lo),
        .tc_enable(tc_lo),
        .valid_mask(irq_gate_pkg::LO_MASK),
        .rt_halted(RT_HALTED),
        .request(req_lo)
    );

    irq_select #(
        .W(W)
    ) u_sel_hi (
        .pending(pend_hi),
        .enable(en_hi),
        .tc_enable(tc_hi),
        .valid_mask(irq_gate_pkg::HI_MASK),
        .rt_halted(RT_HALTED),
        .request(req_hi)
    );

    // registered so the sequencer sees glitch-free request levels
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            IRQ_OUT_LO <= irq_gate_pkg::ZERO16;
            IRQ_OUT_HI <= irq_gate_pkg::ZERO16;
        end else begin
            IRQ_OUT_LO <= req_lo; // R20
            IRQ_OUT_HI <= req_hi; // R20
        end
    end

    chk_reset_enables: assert property ( // R4
        @(posedge SYS_CLK) $fell(RESET) |-> (en_lo == 16'h0000
                                             && en_hi == 16'h0000))
        else $error("enables not cleared by reset");

    chk_reset_debug: assert property ( // R15
        @(posedge SYS_CLK) $fell(RESET) |-> (tc_lo == 16'h0000
                                             && tc_hi == 16'h0000))
        else $error("debug enables not cleared by reset");

    chk_w1c_clear: assert property ( // R2
        @(posedge SYS_CLK) disable iff (RESET)
        (wr_now && AVS_ADDRESS == irq_gate_pkg::OFS_PEND_LO
         && AVS_BYTEENABLE == 4'hf && IRQ_IN_LO == irq_gate_pkg::ZERO16)
        |=> ((pend_lo & $past(AVS_WRITEDATA[15:0])) == irq_gate_pkg::ZERO16))
        else $error("pending flag not cleared by write of one");

    chk_set_wins: assert property ( // R17
        @(posedge SYS_CLK) disable iff (RESET)
        (IRQ_IN_LO != irq_gate_pkg::ZERO16)
        |=> ((pend_lo & $past(IRQ_IN_LO))
             == ($past(IRQ_IN_LO) & irq_gate_pkg::LO_MASK)))
        else $error("request lost against clear");

    chk_reserved_zero: assert property ( // R10
        @(posedge SYS_CLK) disable iff (RESET)
        (en_lo[1:0] == 2'b00) && (en_hi[15:11] == 5'h00)
        && (tc_hi[15:11] == 5'h00) && (pend_lo[1:0] == 2'b00)
        && (tc_lo[1:0] == 2'b00) && (pend_hi[15:11] == 5'h00))
        else $error("reserved bits not zero");

    chk_running_gate: assert property ( // R11
        @(posedge SYS_CLK) disable iff (RESET)
        !RT_HALTED |=> (IRQ_OUT_LO == (($past(pend_lo) & $past(en_lo))
                                        & irq_gate_pkg::LO_MASK)))
        else $error("running gating wrong");

    chk_halted_gate: assert property ( // R12
        @(posedge SYS_CLK) disable iff (RESET)
        RT_HALTED |=> (IRQ_OUT_HI == ($past(pend_hi) & $past(en_hi)
                                      & $past(tc_hi))))
        else $error("halted gating wrong");

    sequence s_write_en;
        wr_now && AVS_ADDRESS == irq_gate_pkg::OFS_EN_HI
        && AVS_BYTEENABLE == 4'hf;
    endsequence

    chk_enable_write: assert property ( // R7
        @(posedge SYS_CLK) disable iff (RESET)
        s_write_en |=> (en_hi == ($past(AVS_WRITEDATA[15:0])
                                  & irq_gate_pkg::HI_MASK)))
        else $error("enable high write wrong");

    chk_ack_clears: assert property ( // R18
        @(posedge SYS_CLK) disable iff (RESET)
        (ACK_LO[3] && !IRQ_IN_LO[3]) |=> !pend_lo[3])
        else $error("acknowledge did not clear flag");

    chk_bus_answer: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        ((AVS_READ || AVS_WRITE) && bus_state == irq_gate_pkg::BUS_IDLE)
        |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus answer timing wrong");

    chk_reset_pending: assert property ( // R19
        @(posedge SYS_CLK) $fell(RESET) |-> (pend_lo == irq_gate_pkg::ZERO16
                                             && pend_hi == irq_gate_pkg::ZERO16))
        else $error("pending flags not cleared by reset");

    sequence s_soft_reset;
        wr_now && AVS_ADDRESS == irq_gate_pkg::OFS_CTRL
        && wdata[irq_gate_pkg::CTRL_SOFT_RESET];
    endsequence

    chk_soft_keeps: assert property ( // R5 R14
        @(posedge SYS_CLK) disable iff (RESET)
        s_soft_reset |=> ($stable(en_lo) && $stable(en_hi)
                          && $stable(tc_lo) && $stable(tc_hi)))
        else $error("software reset changed enables");

    sequence s_write_tc_lo;
        wr_now && AVS_ADDRESS == irq_gate_pkg::OFS_TC_LO
        && (&AVS_BYTEENABLE[1:0]);
    endsequence

    chk_tc_write: assert property ( // R13
        @(posedge SYS_CLK) disable iff (RESET)
        s_write_tc_lo |=> (tc_lo == ($past(AVS_WRITEDATA[15:0])
                                     & irq_gate_pkg::LO_MASK)))
        else $error("debug enable low write wrong");

    sequence s_write_en_lo;
        wr_now && AVS_ADDRESS == irq_gate_pkg::OFS_EN_LO
        && (&AVS_BYTEENABLE[1:0]);
    endsequence

    chk_enable_low: assert property ( // R9
        @(posedge SYS_CLK) disable iff (RESET)
        s_write_en_lo |=> (en_lo == ($past(AVS_WRITEDATA[15:0])
                                     & irq_gate_pkg::LO_MASK)))
        else $error("enable low write wrong");

    chk_pend_read: assert property ( // R1
        @(posedge SYS_CLK) disable iff (RESET)
        (AVS_READ && bus_state == irq_gate_pkg::BUS_IDLE
         && AVS_ADDRESS == irq_gate_pkg::OFS_PEND_LO)
        |=> (AVS_READDATA[15:0] == $past(pend_lo)))
        else $error("pending flag read wrong");

    chk_halted_lo: assert property ( // R12
        @(posedge SYS_CLK) disable iff (RESET)
        RT_HALTED |=> (IRQ_OUT_LO == ($past(pend_lo) & $past(en_lo)
                                      & $past(tc_lo))))
        else $error("halted low gating wrong");

    chk_running_hi: assert property ( // R11
        @(posedge SYS_CLK) disable iff (RESET)
        !RT_HALTED |=> (IRQ_OUT_HI == ($past(pend_hi) & $past(en_hi)
                                       & irq_gate_pkg::HI_MASK)))
        else $error("running high gating wrong");
endmodule : irq_gate

/* testbench/irq_partner.sv */
`timescale 1ns/1ps
// far side: request sources and the cpu interrupt sequencer
module irq_partner (
    input wire logic clk,
    input wire logic [15:0] fire_lo,
    input wire logic [15:0] fire_hi,
    input wire logic auto_ack,
    input wire logic [15:0] out_lo,
    input wire logic [15:0] out_hi,
    output logic [15:0] req_lo = 16'h0000,
    output logic [15:0] req_hi = 16'h0000,
    output logic [15:0] ack_lo = 16'h0000,
    output logic [15:0] ack_hi = 16'h0000
);
    logic [15:0] held_lo = 16'h0000;
    logic [15:0] held_hi = 16'h0000;
    always @(posedge clk) begin
        req_lo <= fire_lo;
        req_hi <= fire_hi;
    end
    // the request line lags the ack by two edges, so hold off a re-ack
    always @(posedge clk) begin
        ack_lo <= auto_ack ? out_lo & ~ack_lo & ~held_lo : 16'h0000;
        ack_hi <= auto_ack ? out_hi & ~ack_hi & ~held_hi : 16'h0000;
        held_lo <= ack_lo;
        held_hi <= ack_hi;
    end
endmodule : irq_partner

/* testbench/maskable_irq_enable_gating_test.sv */
`timescale 1ns/1ps
module maskable_irq_enable_gating_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    logic waitreq;
    logic [15:0] in_lo, in_hi, ack_lo, ack_hi, out_lo, out_hi;
    logic [15:0] fire_lo = 16'h0000;
    logic [15:0] fire_hi = 16'h0000;
    logic auto_ack = 1'b0;
    logic halted = 1'b0;
    logic [3:0] be = 4'hf;
    logic [15:0] m;
    int error_cnt = 0;
    int checks_done = 0;
    always #2 clk = ~clk;
    irq_gate #(.W(16)) irq_gate_i (.SYS_CLK(clk), .RESET(reset),
        .AVS_ADDRESS(address), .AVS_READ(read), .AVS_WRITE(write),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
        .IRQ_IN_LO(in_lo), .IRQ_IN_HI(in_hi), .ACK_LO(ack_lo),
        .ACK_HI(ack_hi), .RT_HALTED(halted), .IRQ_OUT_LO(out_lo),
        .IRQ_OUT_HI(out_hi));
    irq_partner irq_partner_i (.clk(clk), .fire_lo(fire_lo),
        .fire_hi(fire_hi), .auto_ack(auto_ack), .out_lo(out_lo),
        .out_hi(out_hi), .req_lo(in_lo), .req_hi(in_hi),
        .ack_lo(ack_lo), .ack_hi(ack_hi));
    task check(input string what, input logic [15:0] seen,
               input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task bus(input logic wr, input logic [3:0] a, input logic [15:0] d,
             output logic [15:0] q);
        address <= a;
        wdata <= {16'h0000, d};
        write <= wr;
        read <= ~wr;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        q = rdata[15:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task reg_wr(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] q;
        bus(1'b1, a, d, q);
    endtask : reg_wr
    task reg_chk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] q;
        bus(1'b0, a, 16'h0000, q);
        check($sformatf("reg %0d", a), q, exp);
    endtask : reg_chk
    task pulse(input logic [15:0] lo, input logic [15:0] hi);
        fire_lo <= lo;
        fire_hi <= hi;
        @(posedge clk);
        fire_lo <= 16'h0000;
        fire_hi <= 16'h0000;
        repeat (4) @(posedge clk);
    endtask : pulse
    task outs(input logic [15:0] lo, input logic [15:0] hi);
        check("out_lo", out_lo, lo);
        check("out_hi", out_hi, hi);
    endtask : outs
    task t_reset_values;
        for (int a = 0; a < 8; a++) reg_chk(4'(a), 16'h0000);
        outs(16'h0000, 16'h0000);
    endtask : t_reset_values
    task t_access;
        for (int a = 2; a < 6; a++) begin
            reg_wr(4'(a), 16'hffff);
            reg_chk(4'(a), a[0] ? 16'h07ff : 16'hfffc);
        end
        reg_wr(4'h4, 16'h0000);
        reg_chk(4'h4, 16'h0000);
        reg_wr(4'h8, 16'hffff);
        reg_chk(4'h8, 16'h0000);
        be <= 4'h1;
        reg_wr(4'h2, 16'h0000);
        be <= 4'hf;
        reg_chk(4'h2, 16'hff00);
    endtask : t_access
    task t_pending;
        pulse(16'hffff, 16'hffff);
        reg_chk(4'h0, 16'hfffc);
        reg_chk(4'h1, 16'h07ff);
        reg_wr(4'h0, 16'h4004);
        reg_wr(4'h1, 16'h0000);
        reg_chk(4'h0, 16'hbff8);
        reg_chk(4'h1, 16'h07ff);
        // the request reaches the flag at the same edge as the clear
        fork
            pulse(16'h0004, 16'h0000);
            reg_wr(4'h0, 16'h0004);
        join
        reg_chk(4'h0, 16'hbffc);
    endtask : t_pending
    task t_gating;
        for (int i = 0; i < 16; i++) begin
            m = 16'h0001 << i;
            reg_wr(4'h2, m & 16'hfffc);
            reg_wr(4'h3, m & 16'h07ff);
            pulse(16'hffff, 16'hffff);
            outs(m & 16'hfffc, m & 16'h07ff);
            reg_wr(4'h0, 16'hffff);
            reg_wr(4'h1, 16'hffff);
            repeat (2) @(posedge clk);
            outs(16'h0000, 16'h0000);
        end
    endtask : t_gating
    task t_halted;
        // enables and debug enables are set before halting
        reg_wr(4'h2, 16'hffdc);
        reg_wr(4'h3, 16'h07ff);
        reg_wr(4'h4, 16'h0030);
        reg_wr(4'h5, 16'h0400);
        halted <= 1'b1;
        pulse(16'hffff, 16'hffff);
        outs(16'h0010, 16'h0400);
        reg_chk(4'h7, 16'h0001);
        halted <= 1'b0;
        repeat (3) @(posedge clk);
        outs(16'hffdc, 16'h07ff);
        auto_ack <= 1'b1;
        repeat (10) @(posedge clk);
        auto_ack <= 1'b0;
        // vector 5 is not enabled, so it is never acknowledged
        reg_chk(4'h0, 16'h0020);
        reg_chk(4'h1, 16'h0000);
    endtask : t_halted
    task t_resets;
        reg_wr(4'h6, 16'h0001);
        reg_chk(4'h7, 16'h0002);
        reg_chk(4'h2, 16'hffdc);
        reg_chk(4'h3, 16'h07ff);
        reg_chk(4'h4, 16'h0030);
        reg_chk(4'h5, 16'h0400);
        reg_wr(4'h7, 16'h0000);
        reg_chk(4'h7, 16'h0000);
        pulse(16'hffff, 16'hffff);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 6; a++) reg_chk(4'(a), 16'h0000);
        outs(16'h0000, 16'h0000);
    endtask : t_resets
    task stop_test;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        stop_test;
    end
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset_values;
        t_access;
        t_pending;
        t_gating;
        t_halted;
        t_resets;
        stop_test;
    end
endmodule : maskable_irq_enable_gating_test
